// File: hw/rxgc_map.svh
`ifndef RXGC_MAP_SVH
`define RXGC_MAP_SVH
`define RXGC_IDX_MIN 8'hbb
`define RXGC_IDX_MAX 8'hff
`define RXGC_IDX_RST 8'hff
`define RXGC_ATTACK_STEP 8'h01
`define RXGC_FAST_STEP 8'h04
`define RXGC_RECOV_STEP 8'h01
`define RXGC_FRONT_END_FULL 9'h100
`endif

// File: hw/rxgc_pkg.sv
`default_nettype none
package rxgc_pkg;
	typedef enum logic [1:0] {
		RXGC_MODE_SELF = 2'h1,
		RXGC_MODE_USER = 2'h2
	} rxgc_mode_t;
	typedef enum logic [1:0] {
		RXGC_ATK_NORMAL = 2'h0,
		RXGC_ATK_FAST = 2'h1,
		RXGC_ATK_FAST_RECOV = 2'h2
	} rxgc_attack_t;
	// one sample of the three detectors
	typedef struct packed {
		logic [15:0] apd_peak;
		logic [15:0] hb_peak;
		logic [15:0] power;
		logic valid;
	} rxgc_det_t;
	// flags on digital general purpose pins
	typedef struct packed {
		logic apd_over;
		logic apd_under;
		logic hb_over;
		logic hb_under;
		logic pwr_over;
		logic pwr_under;
	} rxgc_flags_t;
endpackage
`default_nettype wire

// File: hw/rxgc_ctrl.sv
// Functional notes
// - In self-directed mode the block steps the gain index itself from detector results.
// - In user-directed mode only the processor's commands or pins change the gain index.
// - In user-directed mode with detectors enabled, detector flags appear on the GPIO pins.
// - A high threshold crossing raises a gain attack that lowers the index.
// - A low threshold result raises a gain recovery that raises the index.
// - A detector flags overload when above a threshold and underload otherwise.
// - Overrange is the OR of the peak-based and power-based conditions.
// - Peak overrange fires when high overloads in a window reach a programmed count.
// - Power overrange fires when measured power is above the high power threshold.
// - Fast attack mode reduces the gain index by a larger step.
// - Fast attack and recovery mode also recovers with a larger step.
// - With compensation on, digital gain equals the front-end attenuation applied.
// - Underrange fires when low-threshold hits in a window stay under a count or power is low, unless overrange fires too.
// - The gain index stays within 187 through 255.
`include "rxgc_map.svh"
`default_nettype none
module rxgc_ctrl #(
	parameter int CNT_W = 8,
	parameter int WIN_W = 16
) (
	input wire logic clk_sys_i, // 10 MHz
	input wire logic rst_n_i, // async reset
	input wire rxgc_pkg::rxgc_mode_t mode_i, // gain mode
	input wire rxgc_pkg::rxgc_attack_t attack_i, // attack option
	input wire logic det_en_i, // detectors enabled
	input wire logic comp_en_i, // gain compensation on
	input wire rxgc_pkg::rxgc_det_t det_i, // detector sample
	input wire logic [15:0] pk_hi_thr_i, // peak high threshold
	input wire logic [15:0] pk_lo_thr_i, // peak low threshold
	input wire logic [15:0] pwr_hi_thr_i, // power high threshold
	input wire logic [15:0] pwr_lo_thr_i, // power low threshold
	input wire logic [CNT_W-1:0] over_cnt_i, // overloads for overrange
	input wire logic [CNT_W-1:0] under_cnt_i, // hits needed to block
	input wire logic [WIN_W-1:0] win_len_i, // window in samples
	input wire logic [7:0] fe_atten_i, // front-end word of index
	input wire logic user_gain_wr_i, // software gain command
	input wire logic [7:0] user_gain_i, // commanded index
	input wire logic gpio_inc_i, // pin gain up (async)
	input wire logic gpio_dec_i, // pin gain down (async)
	output rxgc_pkg::rxgc_flags_t gpio_flags_o, // flags to pins
	output logic overrange_o, // overrange seen
	output logic underrange_o, // underrange seen
	output logic [7:0] gain_idx_o, // gain table index
	output logic [8:0] dig_comp_o // compensation in steps
);
	logic [1:0] inc_sync;
	logic [1:0] dec_sync;
	logic inc_d;
	logic dec_d;
	logic [CNT_W-1:0] over_hits;
	logic [CNT_W-1:0] under_hits;
	logic [WIN_W-1:0] win_cnt;
	logic pk_over_seen;
	logic [7:0] gain_idx;
	logic [7:0] next_gain_idx;
	rxgc_pkg::rxgc_flags_t flags;
	wire self_mode = (mode_i == rxgc_pkg::RXGC_MODE_SELF);
	wire user_mode = (mode_i == rxgc_pkg::RXGC_MODE_USER);
	wire win_end = det_i.valid && (win_cnt >= win_len_i);
	wire apd_over = det_i.apd_peak > pk_hi_thr_i;
	wire hb_over = det_i.hb_peak > pk_hi_thr_i;
	wire apd_lo_hit = det_i.apd_peak > pk_lo_thr_i;
	wire hb_lo_hit = det_i.hb_peak > pk_lo_thr_i;
	wire pwr_over = det_i.power > pwr_hi_thr_i;
	wire pwr_low = !(det_i.power > pwr_lo_thr_i);
	wire hi_hit = det_i.valid && (apd_over || hb_over);
	wire lo_hit = det_i.valid && (apd_lo_hit || hb_lo_hit);
	// count high overloads inside the window
	wire [CNT_W-1:0] over_next = over_hits + CNT_W'(hi_hit);
	wire pk_over = hi_hit && (over_next >= over_cnt_i) && !pk_over_seen;
	// low-threshold hits counted to window end
	wire [CNT_W-1:0] under_next = under_hits + CNT_W'(lo_hit);
	wire pk_under = win_end && (under_next < under_cnt_i);
	wire pwr_ovr = det_i.valid && pwr_over;
	wire ovr = pk_over || pwr_ovr;
	wire unr = pk_under || (det_i.valid && pwr_low);
	// larger attack step in fast modes
	wire [7:0] atk_step = (attack_i == rxgc_pkg::RXGC_ATK_NORMAL) ?
		`RXGC_ATTACK_STEP : `RXGC_FAST_STEP;
	// larger recovery step only in fast attack and recovery
	wire [7:0] rec_step = (attack_i == rxgc_pkg::RXGC_ATK_FAST_RECOV) ?
		`RXGC_FAST_STEP : `RXGC_RECOV_STEP;
	wire [8:0] dn_val = {1'b0, gain_idx} - {1'b0, atk_step};
	wire [8:0] up_val = {1'b0, gain_idx} + {1'b0, rec_step};
	wire [7:0] idx_dn = (dn_val[8] || dn_val[7:0] < `RXGC_IDX_MIN) ?
		`RXGC_IDX_MIN : dn_val[7:0];
	wire [7:0] idx_up = (up_val > {1'b0, `RXGC_IDX_MAX}) ?
		`RXGC_IDX_MAX : up_val[7:0];
	wire [7:0] idx_cmd = (user_gain_i < `RXGC_IDX_MIN) ? `RXGC_IDX_MIN :
		user_gain_i;
	wire pin_up = inc_sync[1] && !inc_d;
	wire pin_dn = dec_sync[1] && !dec_d;
	always_comb begin
		next_gain_idx = gain_idx;
		if (self_mode && det_en_i) begin
			if (ovr) begin
				next_gain_idx = idx_dn;
			end else if (unr) begin
				next_gain_idx = idx_up;
			end
		end else if (user_mode) begin
			// only processor commands or pin steps move the index
			if (user_gain_wr_i) begin
				next_gain_idx = idx_cmd;
			end else if (pin_dn) begin
				next_gain_idx = idx_dn;
			end else if (pin_up) begin
				next_gain_idx = idx_up;
			end
		end
	end
	always_comb begin
		flags = '0;
		// detector indications to pins in user mode
		if (user_mode && det_en_i && det_i.valid) begin
			flags.apd_over = apd_over;
			flags.apd_under = !apd_over;
			flags.hb_over = hb_over;
			flags.hb_under = !hb_over;
			flags.pwr_over = pwr_over;
			flags.pwr_under = !pwr_over;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inc_sync <= 2'h0;
			dec_sync <= 2'h0;
			inc_d <= 1'b0;
			dec_d <= 1'b0;
		end else begin
			inc_sync <= {inc_sync[0], gpio_inc_i};
			dec_sync <= {dec_sync[0], gpio_dec_i};
			inc_d <= inc_sync[1];
			dec_d <= dec_sync[1];
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt <= '0;
			over_hits <= '0;
			under_hits <= '0;
			pk_over_seen <= 1'b0;
		end else if (!det_en_i || win_end) begin
			win_cnt <= '0;
			over_hits <= '0;
			under_hits <= '0;
			pk_over_seen <= 1'b0;
		end else if (det_i.valid) begin
			win_cnt <= win_cnt + WIN_W'(1);
			over_hits <= over_next;
			under_hits <= under_next;
			pk_over_seen <= pk_over_seen || pk_over;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_idx <= `RXGC_IDX_RST;
			gpio_flags_o <= '0;
			overrange_o <= 1'b0;
			underrange_o <= 1'b0;
			dig_comp_o <= 9'h000;
		end else begin
			gain_idx <= next_gain_idx;
			gpio_flags_o <= flags;
			overrange_o <= det_en_i && ovr;
			underrange_o <= det_en_i && unr && !ovr;
			dig_comp_o <= comp_en_i ? `RXGC_FRONT_END_FULL -
				{1'b0, 8'hff - fe_atten_i} - 9'h001 : 9'h000;
		end
	end
	assign gain_idx_o = gain_idx;
	a_idx_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		gain_idx >= `RXGC_IDX_MIN) else $error("gain index below range");
	a_user_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		user_mode && !user_gain_wr_i && !pin_up && !pin_dn |=>
		$stable(gain_idx)) else $error("gain moved without command");
	a_attack_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		self_mode && det_en_i && ovr && gain_idx > `RXGC_IDX_MIN |=>
		gain_idx < $past(gain_idx)) else $error("attack not taken");
	a_recov_up: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		self_mode && det_en_i && !ovr && unr && gain_idx < `RXGC_IDX_MAX |=>
		gain_idx > $past(gain_idx)) else $error("recovery not taken");
	a_ovr_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		det_en_i && (pwr_ovr || pk_over) |=> overrange_o)
		else $error("overrange missed");
	a_unr_excl: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!(overrange_o && underrange_o)) else $error("both ranges flagged");
	a_flags_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!user_mode ##1 !user_mode |-> gpio_flags_o == '0)
		else $error("flags on pins in self mode");
	a_fast_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		self_mode && det_en_i && ovr && attack_i != rxgc_pkg::RXGC_ATK_NORMAL
		&& gain_idx >= 8'hc0 |=> gain_idx == $past(gain_idx) - 8'h04)
		else $error("fast attack step wrong");
	a_recov_fast: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		self_mode && det_en_i && !ovr && unr &&
		attack_i == rxgc_pkg::RXGC_ATK_FAST_RECOV && gain_idx <= 8'hfb |=>
		gain_idx == $past(gain_idx) + `RXGC_FAST_STEP)
		else $error("fast recovery step wrong");
	a_under_flag: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		det_en_i && unr && !ovr |=> underrange_o)
		else $error("underrange missed");
	// no self step with detectors off
	a_self_hold: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		self_mode && !det_en_i |=> $stable(gain_idx))
		else $error("gain moved with detectors off");
	a_comp_match: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		comp_en_i |=> dig_comp_o == {1'b0, $past(fe_atten_i)})
		else $error("compensation differs from attenuation");
endmodule
`default_nettype wire

// File: verif/rxgc_bbp.sv
`default_nettype none
module rxgc_bbp (
	input wire logic clk_sys_i, // system clock
	output logic gain_wr_o, // gain command strobe
	output logic [7:0] gain_o, // commanded index
	output logic inc_o, // pin gain up
	output logic dec_o // pin gain down
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		gain_wr_o = 1'b0;
		gain_o = 8'h00;
		inc_o = 1'b0;
		dec_o = 1'b0;
	end
	task automatic send(input logic [7:0] g);
		@(negedge clk_sys_i);
		gain_wr_o = 1'b1;
		gain_o = g;
		@(negedge clk_sys_i);
		gain_wr_o = 1'b0;
		gain_o = ~g;
	endtask
	task automatic pin_up();
		@(negedge clk_sys_i);
		inc_o = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		inc_o = 1'b0;
	endtask
	// pin step down held past synchroniser
	task automatic pin_dn();
		@(negedge clk_sys_i);
		dec_o = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		dec_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/rxgc_ctrl_tb.sv
`default_nettype none
module rxgc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	rxgc_pkg::rxgc_mode_t mode = rxgc_pkg::RXGC_MODE_SELF;
	rxgc_pkg::rxgc_attack_t atk = rxgc_pkg::RXGC_ATK_NORMAL;
	logic det_en = 1'b1;
	logic comp_en = 1'b0;
	logic [7:0] fe = 8'h00;
	logic [15:0] pk_hi = 16'hffff;
	logic [15:0] pwr_hi = 16'h8000;
	logic [15:0] pk_lo = 16'h0000;
	logic [15:0] pwr_lo = 16'h0000;
	logic [7:0] over_cnt = 8'hff;
	logic [7:0] under_cnt = 8'h00;
	rxgc_pkg::rxgc_det_t det = '0;
	logic wr, inc, dec, ovr, und;
	logic [7:0] ug, idx;
	logic [8:0] comp;
	rxgc_pkg::rxgc_flags_t flags;
	int error_cnt = 0;
	int num_checks = 0;
	initial forever #50 clk_sys_i = ~clk_sys_i;
	rxgc_bbp rxgc_bbp_inst (.clk_sys_i(clk_sys_i), .gain_wr_o(wr),
		.gain_o(ug), .inc_o(inc), .dec_o(dec));
	rxgc_ctrl rxgc_ctrl_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.mode_i(mode), .attack_i(atk), .det_en_i(det_en),
		.comp_en_i(comp_en), .det_i(det), .pk_hi_thr_i(pk_hi),
		.pk_lo_thr_i(pk_lo), .pwr_hi_thr_i(pwr_hi),
		.pwr_lo_thr_i(pwr_lo), .over_cnt_i(over_cnt),
		.under_cnt_i(under_cnt), .win_len_i(16'h000f), .fe_atten_i(fe),
		.user_gain_wr_i(wr),
		.user_gain_i(ug), .gpio_inc_i(inc), .gpio_dec_i(dec),
		.gpio_flags_o(flags), .overrange_o(ovr), .underrange_o(und),
		.gain_idx_o(idx), .dig_comp_o(comp));
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// one valid detector sample, outputs settle by the next falling edge
	task automatic samp(input logic [15:0] a, input logic [15:0] h,
		input logic [15:0] p);
		@(negedge clk_sys_i);
		det = '{a, h, p, 1'b1};
		@(negedge clk_sys_i);
		det.valid = 1'b0;
	endtask
	task automatic hit(input logic [15:0] p);
		samp(16'h0000, 16'h0000, p);
	endtask
	task automatic t_reset();
		chk("idx", idx, 16'h00ff);
		chk("ovr", ovr, 16'h0000);
		chk("comp", comp, 16'h0000);
	endtask
	task automatic t_attack();
		hit(16'h9000);
		chk("ovr", ovr, 16'h0001);
		chk("und", und, 16'h0000);
		chk("idx", idx, 16'h00fe);
		atk = rxgc_pkg::RXGC_ATK_FAST;
		hit(16'h9000);
		chk("idx", idx, 16'h00fa);
		atk = rxgc_pkg::RXGC_ATK_FAST_RECOV;
		hit(16'h9000);
		chk("idx", idx, 16'h00f6);
		det_en = 1'b0;
		hit(16'h9000);
		chk("idx", idx, 16'h00f6);
		det_en = 1'b1;
	endtask
	task automatic t_recov();
		pwr_lo = 16'h0200;
		hit(16'h0100);
		chk("und", und, 16'h0001);
		chk("ovr", ovr, 16'h0000);
		chk("idx", idx, 16'h00fa);
		atk = rxgc_pkg::RXGC_ATK_NORMAL;
		hit(16'h0100);
		chk("idx", idx, 16'h00fb);
		pwr_lo = 16'hffff;
		hit(16'h9000);
		chk("ovr", ovr, 16'h0001);
		chk("und", und, 16'h0000);
		chk("idx", idx, 16'h00fa);
		pwr_lo = 16'h0000;
		over_cnt = 8'h02;
		pk_hi = 16'h4000;
		samp(16'h5000, 16'h0000, 16'h0100);
		chk("ovr", ovr, 16'h0000);
		samp(16'h0000, 16'h5000, 16'h0100);
		chk("ovr", ovr, 16'h0001);
		chk("idx", idx, 16'h00f9);
		samp(16'h5000, 16'h0000, 16'h0100);
		chk("ovr", ovr, 16'h0000);
		chk("idx", idx, 16'h00f9);
		under_cnt = 8'hff;
		det_en = 1'b0;
		@(negedge clk_sys_i);
		det_en = 1'b1;
		repeat (15) hit(16'h0100);
		chk("und", und, 16'h0000);
		chk("idx", idx, 16'h00f9);
		hit(16'h0100);
		chk("und", und, 16'h0001);
		chk("idx", idx, 16'h00fa);
		pk_lo = 16'h0200;
		under_cnt = 8'h01;
		samp(16'h0300, 16'h0000, 16'h0100);
		repeat (15) hit(16'h0100);
		chk("und", und, 16'h0000);
		chk("idx", idx, 16'h00fa);
		under_cnt = 8'h00;
		over_cnt = 8'hff;
		pk_hi = 16'hffff;
	endtask
	task automatic t_user();
		mode = rxgc_pkg::RXGC_MODE_USER;
		hit(16'h9000);
		chk("idx", idx, 16'h00fa);
		chk("pwr_over", flags.pwr_over, 16'h0001);
		chk("flags", flags, 16'h0016);
		hit(16'h0100);
		chk("pwr_over", flags.pwr_over, 16'h0000);
		chk("flags", flags, 16'h0015);
		pk_hi = 16'h4000;
		samp(16'h5000, 16'h0000, 16'h0100);
		chk("flags", flags, 16'h0025);
		chk("idx", idx, 16'h00fa);
		pk_hi = 16'hffff;
		det_en = 1'b0;
		hit(16'h9000);
		chk("flags", flags, 16'h0000);
		det_en = 1'b1;
		rxgc_bbp_inst.send(8'h10);
		chk("idx", idx, 16'h00bb);
		rxgc_bbp_inst.pin_up();
		chk("idx", idx, 16'h00bc);
		rxgc_bbp_inst.pin_dn();
		chk("idx", idx, 16'h00bb);
		rxgc_bbp_inst.send(8'hff);
		chk("idx", idx, 16'h00ff);
		rxgc_bbp_inst.pin_up();
		chk("idx", idx, 16'h00ff);
	endtask
	task automatic t_comp();
		fe = 8'h20;
		comp_en = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk("comp", comp, 16'h0020);
		comp_en = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("comp", comp, 16'h0000);
	endtask
	initial begin
		#(3000 * 100);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (12) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		t_reset();
		t_attack();
		t_recov();
		t_user();
		t_comp();
		stop_test();
	end
endmodule
`default_nettype wire
